//--- port_ctrl_pkg.sv
// Constants, register map and carrier types for the downstream port controller
//
// Operation
// - Module address query returns the factory default base address 6.
// - A per-unit serial number set at manufacture is readable on request.
// - Save copies the configuration to storage; only boost changes wait for save plus reboot, the rest apply at once.
// - Boost settings stay inactive until a save and then a reset follow.
// - Two button presses within 5 s restore defaults: all on, CDP, delay 0, 2500 mA.
// - The saved set holds offset, rate, router, delay, boot slot, boosts, per-port settings.
// - Combined enable or disable switches a channel's data and Vbus together.
// - Data-only commands leave the Vbus setting alone; both aliases act identically.
// - Power-only commands switch Vbus alone and keep the data state.
// - A data change with power on briefly cycles that port's Vbus.
// - Per-channel Vbus voltage in uV and current in uA are readable.
// - A current limit request of 500 mA or more is stored as the nearest allowed value at or below it; lower requests store 500 mA.
// - Allowed limits are 500, 900, 1000, 1200, 1500, 1800, 2000 and 2500 mA.
// - Over-limit draw enters constant-current mode and sets the port's status bit.
// - Further rising draw trips Vbus and data off, sets error and lights the LED.
// - Speed query returns 0 with nothing enumerated and 1 for a high-speed device.
// - Charging mode per port is readable and writable: 0 SDP, 1 CDP.
// - SDP advertises at most 500 mA; CDP advertises up to 5 A.
// - With no upstream host, CDP ports behave as dedicated charging ports.
// - Ports enable in order 0 to 3, spaced by a delay in milliseconds.
// - The staggered sequence runs at power-on and on each new upstream connection.
package port_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_MODULE    = 8'h00;
  localparam logic [7:0] A_SERIAL    = 8'h04;
  localparam logic [7:0] A_CMD       = 8'h08;
  localparam logic [7:0] A_DELAY     = 8'h0C;
  localparam logic [7:0] A_SYSCFG    = 8'h10;
  localparam logic [7:0] A_ACTIVE    = 8'h14;
  localparam logic [7:0] A_STATE0    = 8'h20;
  localparam logic [7:0] A_LIMIT0    = 8'h30;
  localparam logic [7:0] A_VOLT0     = 8'h40;
  localparam logic [7:0] A_CURR0     = 8'h50;
  localparam logic [7:0] A_SPEED0    = 8'h60;
  localparam logic [7:0] A_MODE0     = 8'h70;

  // Command word: [3:0] opcode, [7:4] channel
  localparam logic [3:0] OP_PORT_EN  = 4'h1;
  localparam logic [3:0] OP_PORT_DIS = 4'h2;
  localparam logic [3:0] OP_DATA_EN  = 4'h3;
  localparam logic [3:0] OP_DATA_DIS = 4'h4;
  localparam logic [3:0] OP_HS_EN    = 4'h5;
  localparam logic [3:0] OP_HS_DIS   = 4'h6;
  localparam logic [3:0] OP_PWR_EN   = 4'h7;
  localparam logic [3:0] OP_PWR_DIS  = 4'h8;
  localparam logic [3:0] OP_SAVE     = 4'h9;
  localparam logic [3:0] OP_CLR_ERR  = 4'hA;

  // Port state bit positions
  localparam int ST_VBUS = 0;
  localparam int ST_DATA = 1;
  localparam int ST_ERR  = 19;
  localparam int ST_BST  = 20;
  localparam int ST_ATT  = 23;
  localparam int ST_CC   = 24;

  // ----------------------------------------------------------------------
  // Defaults and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  MODULE_ADDR   = 8'h06;
  localparam logic [31:0] LIMIT_DEF_UA  = 32'h0026_25A0;  // 2500 mA
  localparam logic [31:0] DELAY_DEF_MS  = 32'h0000_0000;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          MS_CYC        = CLK_HZ / 1000;
  localparam int          DBL_PRESS_S   = 5;
  localparam int          DBL_PRESS_CYC = DBL_PRESS_S * CLK_HZ;
  localparam int          VBUS_OFF_US   = 100;
  localparam int          VBUS_OFF_CYC  = (VBUS_OFF_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int          NPORT         = 4;

  // Allowed limits in microamps, ascending
  localparam logic [31:0] LIM_TAB [8] = '{
    32'h0007_A120, 32'h000D_BBA0, 32'h000F_4240, 32'h0012_4F80,
    32'h0016_E360, 32'h001B_7740, 32'h001E_8480, 32'h0026_25A0};

  typedef struct packed {
    logic       data_en;
    logic       vbus_en;
    logic       cdp;
    logic [31:0] limit;
  } port_cfg_t;

  typedef struct packed {
    logic [1:0] up_boost;
    logic [1:0] dn_boost;
    logic [3:0] boot_slot;
    logic [7:0] router;
    logic [7:0] i2c_rate;
    logic [7:0] sw_offset;
  } sys_cfg_t;

  typedef struct packed {
    logic [31:0] volt_uv;
    logic [31:0] curr_ua;
    logic        over;    // draw above limit
    logic        rising;  // draw still rising while limited
    logic        hs_enum;
  } port_meas_t;

endpackage

//--- port_ctrl.sv
// Downstream port controller: APB registers, port switching, limits, stagger
`timescale 1ns/1ps
module port_ctrl
  import port_ctrl_pkg::*;
#(
  parameter logic [31:0] SERIAL_NUM = 32'h1234_5678,  // Arbitrary value, set per unit
  parameter int          PRESS_CYC  = DBL_PRESS_CYC,
  parameter int          MS_CYCLES  = MS_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire port_meas_t [NPORT-1:0] meas_i,
  input  wire logic                  button_i,
  input  wire logic                  upstream_i,
  input  wire sys_cfg_t              nv_sys_i,
  input  wire port_cfg_t [NPORT-1:0] nv_port_i,
  input  wire logic [31:0]           nv_delay_i,
  input  wire logic                  nv_valid_i,
  output sys_cfg_t                   nv_sys_o,
  output port_cfg_t [NPORT-1:0]      nv_port_o,
  output logic      [31:0]           nv_delay_o,
  output logic                       nv_save_o,
  output logic      [NPORT-1:0]      data_sw_o,
  output logic      [NPORT-1:0]      vbus_sw_o,
  output logic      [NPORT-1:0]      cc_o,
  output logic      [NPORT-1:0]      err_led_o,
  output logic      [NPORT-1:0]      cdp_o,
  output logic      [NPORT-1:0]      dcp_o,
  output logic      [1:0]            up_boost_o,
  output logic      [1:0]            dn_boost_o
);

  if (PRESS_CYC < 2 || MS_CYCLES < 1) begin : g_bad_counts
    $error("port_ctrl: counts must be positive");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] round_limit(input logic [31:0] req);
    logic [31:0] r;
    r = LIM_TAB[0];  // Below the lowest step the lowest step is kept
    for (int k = 0; k < 8; k++) begin
      if (req >= LIM_TAB[k]) r = LIM_TAB[k];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers (button, upstream)
  // ----------------------------------------------------------------------
  logic [2:0] btn_sync_ff;
  logic [2:0] up_sync_ff;
  logic       btn_ff;
  logic       up_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      btn_sync_ff <= 3'b000;
      up_sync_ff  <= 3'b111;  // Host assumed at reset: no false connect edge
      btn_ff      <= 1'b0;
      up_ff       <= 1'b1;
    end else begin
      btn_sync_ff <= {btn_sync_ff[1:0], button_i};
      up_sync_ff  <= {up_sync_ff[1:0], upstream_i};
      if (btn_sync_ff[2] == btn_sync_ff[1]) btn_ff <= btn_sync_ff[2];
      if (up_sync_ff[2] == up_sync_ff[1]) up_ff <= up_sync_ff[2];
    end
  end

  logic btn_prev_ff;
  logic up_prev_ff;
  logic press;
  logic up_rise;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      btn_prev_ff <= 1'b0;
      up_prev_ff  <= 1'b1;
    end else begin
      btn_prev_ff <= btn_ff;
      up_prev_ff  <= up_ff;
    end
  end

  assign press   = btn_ff & ~btn_prev_ff;
  assign up_rise = up_ff & ~up_prev_ff;

  // ----------------------------------------------------------------------
  // Double press detector
  // ----------------------------------------------------------------------
  logic [31:0] press_cnt_ff;
  logic        armed_ff;
  logic        factory;

  assign factory = press & armed_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_ff     <= 1'b0;
      press_cnt_ff <= 32'h0000_0000;
    end else if (press) begin
      armed_ff     <= ~armed_ff;
      press_cnt_ff <= 32'(PRESS_CYC - 1);
    end else if (armed_ff) begin
      if (press_cnt_ff == 32'h0000_0000) armed_ff <= 1'b0;
      press_cnt_ff <= press_cnt_ff - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Load of saved settings after reset
  // ----------------------------------------------------------------------
  logic loaded_ff;
  logic load;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) loaded_ff <= 1'b0;
    else         loaded_ff <= 1'b1;
  end

  assign load = ~loaded_ff;

  // ----------------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------------
  logic       wr;
  logic       rd_ok;
  logic [1:0] ch_a;
  logic [3:0] op;
  logic [3:0] cmd_ch;
  logic       cmd;
  logic       ch_ok;

  assign pready_o  = 1'b1;
  assign wr        = psel_i & penable_i & pwrite_i;
  assign ch_a      = paddr_i[3:2];
  assign op        = pwdata_i[3:0];
  assign cmd_ch    = pwdata_i[7:4];
  assign cmd       = wr & (paddr_i == A_CMD);
  assign ch_ok     = cmd_ch < 4'(NPORT);

  // ----------------------------------------------------------------------
  // System settings
  // ----------------------------------------------------------------------
  sys_cfg_t    sys_ff;
  sys_cfg_t    sys_act_ff;
  logic [31:0] delay_ff;
  logic        save_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_ff     <= '0;
      sys_act_ff <= '0;
      delay_ff   <= DELAY_DEF_MS;
    end else if (load) begin
      if (nv_valid_i) begin
        sys_ff     <= nv_sys_i;
        sys_act_ff <= nv_sys_i;
        delay_ff   <= nv_delay_i;
      end
    end else if (factory) begin
      sys_ff.up_boost <= 2'b00;
      sys_ff.dn_boost <= 2'b00;
      delay_ff        <= DELAY_DEF_MS;
    end else if (wr && paddr_i == A_SYSCFG) begin
      sys_ff <= pwdata_i[31:0];  // Boost held back from sys_act until reboot
    end else if (wr && paddr_i == A_DELAY) begin
      delay_ff <= pwdata_i;  // stagger_delay_write
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) save_ff <= 1'b0;
    else         save_ff <= (cmd && op == OP_SAVE) | factory;
  end

  assign up_boost_o = sys_act_ff.up_boost;
  assign dn_boost_o = sys_act_ff.dn_boost;
  assign nv_save_o  = save_ff;
  assign nv_sys_o   = sys_ff;
  assign nv_delay_o = delay_ff;

  // ----------------------------------------------------------------------
  // Port settings and trip logic
  // ----------------------------------------------------------------------
  port_cfg_t [NPORT-1:0] cfg_ff;
  logic [NPORT-1:0]      cc_ff;
  logic [NPORT-1:0]      err_ff;
  logic [NPORT-1:0]      blip_req;

  assign nv_port_o = cfg_ff;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic hit;
    assign hit = cmd & ch_ok & (cmd_ch[1:0] == 2'(p));
    assign blip_req[p] = hit & cfg_ff[p].vbus_en &
      ((op == OP_DATA_EN  && !cfg_ff[p].data_en) || (op == OP_HS_EN  && !cfg_ff[p].data_en) ||
       (op == OP_DATA_DIS &&  cfg_ff[p].data_en) || (op == OP_HS_DIS &&  cfg_ff[p].data_en));

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cfg_ff[p] <= '{data_en: 1'b1, vbus_en: 1'b1, cdp: 1'b1, limit: LIMIT_DEF_UA};
      end else if (load) begin
        if (nv_valid_i) cfg_ff[p] <= nv_port_i[p];
      end else if (factory) begin
        cfg_ff[p] <= '{data_en: 1'b1, vbus_en: 1'b1, cdp: 1'b1, limit: LIMIT_DEF_UA};
      end else if (hit) begin
        unique case (op)
          OP_PORT_EN:  begin cfg_ff[p].data_en <= 1'b1; cfg_ff[p].vbus_en <= 1'b1; end
          OP_PORT_DIS: begin cfg_ff[p].data_en <= 1'b0; cfg_ff[p].vbus_en <= 1'b0; end
          OP_DATA_EN, OP_HS_EN:   cfg_ff[p].data_en <= 1'b1;
          OP_DATA_DIS, OP_HS_DIS: cfg_ff[p].data_en <= 1'b0;
          OP_PWR_EN:   cfg_ff[p].vbus_en <= 1'b1;
          OP_PWR_DIS:  cfg_ff[p].vbus_en <= 1'b0;
          default: ;
        endcase
      end else if (err_ff[p] && meas_i[p].over) begin
        ;
      end else if (wr && paddr_i == (A_LIMIT0 + 8'(4 * p))) begin
        cfg_ff[p].limit <= round_limit(pwdata_i);  // current_limit_write
      end else if (wr && paddr_i == (A_MODE0 + 8'(4 * p))) begin
        cfg_ff[p].cdp <= pwdata_i[0];  // charging_mode_write
      end
    end

    // Stage one limits, stage two trips; error holds until cleared
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cc_ff[p]  <= 1'b0;
        err_ff[p] <= 1'b0;
      end else begin
        cc_ff[p] <= meas_i[p].over & vbus_sw_o[p] & ~err_ff[p];
        if (cc_ff[p] && meas_i[p].rising) err_ff[p] <= 1'b1;
        else if (hit && op == OP_CLR_ERR) err_ff[p] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Vbus blip on data-only change
  // ----------------------------------------------------------------------
  logic [NPORT-1:0] blip_ff;
  logic [15:0]      blip_cnt_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blip_ff     <= '0;
      blip_cnt_ff <= 16'h0000;
    end else if (|blip_req) begin
      blip_ff     <= blip_ff | blip_req;
      blip_cnt_ff <= 16'(VBUS_OFF_CYC);
    end else if (blip_cnt_ff != 16'h0000) begin
      blip_cnt_ff <= blip_cnt_ff - 16'h0001;
    end else begin
      blip_ff <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Staggered enable sequence
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_RUN  = 2'b01,
    SQ_DONE = 2'b10
  } seq_t;

  seq_t        seq_ff;
  logic [2:0]  seq_port_ff;
  logic [31:0] ms_cnt_ff;
  logic [31:0] ms_left_ff;
  logic [NPORT-1:0] active_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_ff      <= SQ_RUN;
      seq_port_ff <= 3'd0;
      ms_cnt_ff   <= 32'h0000_0000;
      ms_left_ff  <= 32'h0000_0000;
      active_ff   <= '0;
    end else if (up_rise || load) begin
      seq_ff      <= SQ_RUN;
      seq_port_ff <= 3'd0;
      ms_cnt_ff   <= 32'h0000_0000;
      ms_left_ff  <= 32'h0000_0000;
      active_ff   <= '0;
    end else begin
      unique case (seq_ff)
        SQ_RUN: begin
          if (ms_left_ff == 32'h0000_0000 ||
              (ms_left_ff == 32'h0000_0001 && ms_cnt_ff == 32'(MS_CYCLES - 1))) begin
            active_ff[seq_port_ff[1:0]] <= 1'b1;
            ms_left_ff <= delay_ff;
            ms_cnt_ff  <= 32'h0000_0000;
            seq_port_ff <= seq_port_ff + 3'd1;
            if (seq_port_ff == 3'(NPORT - 1)) seq_ff <= SQ_DONE;
          end else if (ms_cnt_ff == 32'(MS_CYCLES - 1)) begin
            ms_cnt_ff  <= 32'h0000_0000;
            ms_left_ff <= ms_left_ff - 32'h0000_0001;
          end else begin
            ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
          end
        end
        SQ_DONE: ;
        default: seq_ff <= SQ_DONE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Switch outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_sw_o <= '0;
      vbus_sw_o <= '0;
      cc_o      <= '0;
      err_led_o <= '0;
      cdp_o     <= '0;
      dcp_o     <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        data_sw_o[p] <= cfg_ff[p].data_en & active_ff[p] & ~err_ff[p];
        vbus_sw_o[p] <= cfg_ff[p].vbus_en & active_ff[p] & ~err_ff[p] & ~blip_ff[p];
        cdp_o[p]     <= cfg_ff[p].cdp & up_ff;
        dcp_o[p]     <= cfg_ff[p].cdp & ~up_ff;
      end
      cc_o      <= cc_ff;
      err_led_o <= err_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (paddr_i[7:4])
      4'h0: begin
        unique case (paddr_i[3:0])
          4'h0: rdata = {24'h00_0000, MODULE_ADDR};
          4'h4: rdata = SERIAL_NUM;
          4'h8: rdata = 32'h0000_0000;
          4'hC: rdata = delay_ff;
          default: rd_ok = 1'b0;
        endcase
      end
      4'h1: begin
        unique case (paddr_i[3:0])
          4'h0: rdata = sys_ff;
          4'h4: rdata = {28'h000_0000, active_ff};
          default: rd_ok = 1'b0;
        endcase
      end
      4'h2: begin  // port_state_query
        rdata[ST_VBUS] = vbus_sw_o[ch_a];
        rdata[ST_DATA] = data_sw_o[ch_a];
        rdata[ST_ERR]  = err_ff[ch_a];
        rdata[ST_BST]  = |sys_act_ff.dn_boost;
        rdata[ST_ATT]  = meas_i[ch_a].hs_enum;
        rdata[ST_CC]   = cc_ff[ch_a];
      end
      4'h3: rdata = cfg_ff[ch_a].limit;
      4'h4: rdata = meas_i[ch_a].volt_uv;
      4'h5: rdata = meas_i[ch_a].curr_ua;
      4'h6: rdata = {31'h0, meas_i[ch_a].hs_enum};  // enumerated_speed_query
      4'h7: rdata = {31'h0, cfg_ff[ch_a].cdp};
      default: rd_ok = 1'b0;
    endcase
    if (paddr_i[1:0] != 2'b00) rd_ok = 1'b0;
  end

  assign pslverr_o = psel_i & penable_i & ~rd_ok;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) prdata_o <= 32'h0000_0000;
    else         prdata_o <= rdata;
  end

endmodule

//--- downstream_model.sv
// Downstream devices: measurements follow the port switches
`timescale 1ns/1ps
module downstream_model
  import port_ctrl_pkg::*;
(
  input  wire logic [NPORT-1:0]  vbus_i,
  input  wire logic [NPORT-1:0]  over_i,
  input  wire logic [NPORT-1:0]  rise_i,
  input  wire logic [NPORT-1:0]  hs_i,
  output port_meas_t [NPORT-1:0] meas_o
);
  // Without Vbus a device draws nothing and cannot enumerate
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      meas_o[p].volt_uv = vbus_i[p] ? 32'h004C_4B40 : 32'h0000_0000;
      meas_o[p].curr_ua = vbus_i[p] ? 32'h0001_86A0 : 32'h0000_0000;
      meas_o[p].over    = vbus_i[p] & over_i[p];
      meas_o[p].rising  = vbus_i[p] & rise_i[p];
      meas_o[p].hs_enum = vbus_i[p] & hs_i[p];
    end
  end
endmodule

//--- port_ctrl_properties.sv
// Checker for the downstream port controller ports
`timescale 1ns/1ps
module port_ctrl_properties
  import port_ctrl_pkg::*;
#(
  parameter logic [31:0] SERIAL_NUM = 32'h0000_0000,
  parameter int          PRESS_CYC  = DBL_PRESS_CYC,
  parameter int          MS_CYCLES  = MS_CYC
) (
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [7:0]       paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             nv_save_o,
  input wire logic [NPORT-1:0] data_sw_o,
  input wire logic [NPORT-1:0] vbus_sw_o,
  input wire logic [NPORT-1:0] err_led_o,
  input wire logic [NPORT-1:0] cdp_o,
  input wire logic [NPORT-1:0] dcp_o,
  input wire logic [1:0]       up_boost_o,
  input wire logic [1:0]       dn_boost_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic rd_acc;
  logic cmd_wr;
  assign rd_acc = psel_i & penable_i & !pwrite_i;
  assign cmd_wr = psel_i & penable_i & pwrite_i & (paddr_i == A_CMD);

  a_module_addr: assert property (
    rd_acc && paddr_i == A_MODULE |-> prdata_o == {24'h00_0000, MODULE_ADDR})
    else $error("module address read wrong");
  a_serial_read: assert property (
    rd_acc && paddr_i == A_SERIAL |-> prdata_o == SERIAL_NUM)
    else $error("serial number read wrong");
  a_save_pulse: assert property (
    cmd_wr && pwdata_i[3:0] == OP_SAVE |-> ##[1:3] nv_save_o)
    else $error("save command gave no store pulse");
  a_save_single: assert property (nv_save_o |=> !nv_save_o)
    else $error("store pulse longer than one cycle");
  a_boost_frozen: assert property (
    !$stable({up_boost_o, dn_boost_o}) |-> !$past(nrst_i, 2))
    else $error("boost changed outside reset load");
  a_port_off: assert property (
    cmd_wr && pwdata_i[7:0] == {4'h1, OP_PORT_DIS} |-> ##[1:2] !(vbus_sw_o[1] | data_sw_o[1]))
    else $error("port disable left a switch on");
  a_bad_channel: assert property (
    cmd_wr && pwdata_i[7:4] > 4'h3 |=> $stable(vbus_sw_o) && $stable(data_sw_o))
    else $error("out of range channel changed switches");
  a_trip_off: assert property (
    $rose(err_led_o[2]) |-> ##[0:2] !(vbus_sw_o[2] | data_sw_o[2]))
    else $error("trip left port switched on");
  a_charge_excl: assert property (!(|(cdp_o & dcp_o)))
    else $error("port signals both charging kinds");
endmodule

bind port_ctrl port_ctrl_properties #(
  .SERIAL_NUM(SERIAL_NUM), .PRESS_CYC(PRESS_CYC), .MS_CYCLES(MS_CYCLES)
) u_port_ctrl_properties (
  .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .nv_save_o(nv_save_o), .data_sw_o(data_sw_o), .vbus_sw_o(vbus_sw_o),
  .err_led_o(err_led_o), .cdp_o(cdp_o), .dcp_o(dcp_o),
  .up_boost_o(up_boost_o), .dn_boost_o(dn_boost_o)
);

//--- tb_port_ctrl.sv
// Self-checking testbench for the downstream port controller
`timescale 1ns/1ps
module tb_port_ctrl
  import port_ctrl_pkg::*;
;
  localparam logic [31:0] SERNUM = 32'hA5C3_0F1E;  // Arbitrary value
  localparam int          MSC    = 4;
  logic                  clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic                  btn = 1'b0, up = 1'b1, rdy, err, erv, save;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwd = 32'h0000_0000, dly_q = 32'h0000_0002, prd, rdv, dly_o;
  logic [NPORT-1:0]      over = '0, rise = '0, hs = '0, dsw, vsw, cc, led, cdp, dcp;
  logic [1:0]            upb, dnb;
  port_meas_t [NPORT-1:0] meas;
  sys_cfg_t              sys_q = '0, sys_o;
  port_cfg_t [NPORT-1:0] port_q = {NPORT{port_cfg_t'{1'b1, 1'b1, 1'b1, LIMIT_DEF_UA}}}, port_o;
  int                    cyc = 0, error_cnt = 0, check_count = 0;

  port_ctrl #(.SERIAL_NUM(SERNUM), .PRESS_CYC(20), .MS_CYCLES(MSC)) u_port_ctrl (
    .clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .meas_i(meas), .button_i(btn), .upstream_i(up), .nv_sys_i(sys_q), .nv_port_i(port_q),
    .nv_delay_i(dly_q), .nv_valid_i(1'b1), .nv_sys_o(sys_o), .nv_port_o(port_o),
    .nv_delay_o(dly_o), .nv_save_o(save), .data_sw_o(dsw), .vbus_sw_o(vsw), .cc_o(cc),
    .err_led_o(led), .cdp_o(cdp), .dcp_o(dcp), .up_boost_o(upb), .dn_boost_o(dnb));
  downstream_model u_downstream_model (
    .vbus_i(vsw), .over_i(over), .rise_i(rise), .hs_i(hs), .meas_o(meas));

  initial forever #50 clk = ~clk;
  // Storage keeps whatever the last save pulse presented
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (save === 1'b1) begin
      sys_q  <= sys_o;
      port_q <= port_o;
      dly_q  <= dly_o;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rdv = prd;
    erv = err;
    psel <= 1'b0;
    pen  <= 1'b0;
    repeat (2) @(posedge clk);  // Lets registered outputs of a write show
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [3:0] ch);
    apb(1'b1, A_CMD, {24'h00_0000, ch, op});
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
  endtask

  task automatic t_stagger();
    int t [NPORT] = '{default: -1};
    repeat (200) begin
      @(posedge clk);
      for (int p = 0; p < NPORT; p++) if (vsw[p] === 1'b1 && t[p] < 0) t[p] = cyc;
    end
    for (int p = 1; p < NPORT; p++) chk(t[p] - t[p-1], 2 * MSC);
    rd(A_MODULE);
    chk(rdv, {24'h00_0000, MODULE_ADDR});
    rd(A_SERIAL);
    chk(rdv, SERNUM);
    rd(8'hFC);
    chk(erv, 1'b1);
  endtask

  task automatic t_limit();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_LIMIT0 + 8'h04, LIM_TAB[i]);
      rd(A_LIMIT0 + 8'h04);
      chk(rdv, LIM_TAB[i]);
      apb(1'b1, A_LIMIT0 + 8'h04, LIM_TAB[i] + 32'h0000_0001);
      rd(A_LIMIT0 + 8'h04);
      chk(rdv, LIM_TAB[i]);
    end
  endtask

  // Vbus must drop within 20 cycles and come back within 1200 cycles
  task automatic blip();
    int n;
    for (n = 0; n < 20 && vsw[1] !== 1'b0; n++) @(posedge clk);
    chk(vsw[1], 1'b0);
    for (n = 0; n < 1200 && vsw[1] !== 1'b1; n++) @(posedge clk);
    chk(vsw[1], 1'b1);
  endtask

  task automatic t_switch();
    cmd(OP_PORT_DIS, 4'h1);
    chk({vsw[1], dsw[1]}, 2'b00);
    cmd(OP_PORT_EN, 4'h1);
    chk({vsw[1], dsw[1]}, 2'b11);
    for (int i = 0; i < 2; i++) begin
      cmd(i ? OP_HS_DIS : OP_DATA_DIS, 4'h1);
      blip();
      chk(dsw[1], 1'b0);
      cmd(i ? OP_HS_EN : OP_DATA_EN, 4'h1);
      blip();
      chk(dsw[1], 1'b1);
    end
    cmd(OP_PWR_DIS, 4'h1);
    chk({vsw[1], dsw[1]}, 2'b01);
    cmd(OP_PWR_EN, 4'h1);
    cmd(OP_PORT_DIS, 4'h5);
    chk({vsw, dsw}, 8'hFF);
  endtask

  task automatic t_fault();
    over[2] <= 1'b1;
    repeat (2) @(posedge clk);
    rd(A_STATE0 + 8'h08);
    chk({cc[2], rdv[ST_CC]}, 2'b11);
    rise[2] <= 1'b1;
    repeat (5) @(posedge clk);
    rd(A_STATE0 + 8'h08);
    chk({led[2], vsw[2], dsw[2], rdv[ST_ERR]}, 4'h9);
    over[2] <= 1'b0;
    rise[2] <= 1'b0;
    cmd(OP_CLR_ERR, 4'h2);
    chk(led[2], 1'b0);
  endtask

  task automatic t_mode();
    rd(A_SPEED0 + 8'h0C);
    chk(rdv, 32'h0000_0000);
    hs[3] <= 1'b1;
    rd(A_SPEED0 + 8'h0C);
    chk(rdv, 32'h0000_0001);
    rd(A_VOLT0 + 8'h0C);
    chk(rdv, 32'h004C_4B40);
    rd(A_CURR0 + 8'h0C);
    chk(rdv, 32'h0001_86A0);
    apb(1'b1, A_MODE0 + 8'h0C, 32'h0000_0000);
    rd(A_MODE0 + 8'h0C);
    chk(rdv, 32'h0000_0000);
    chk({cdp[3], dcp[3]}, 2'b00);
    apb(1'b1, A_MODE0 + 8'h0C, 32'h0000_0001);
    chk({cdp[3], dcp[3]}, 2'b10);
    up <= 1'b0;
    repeat (6) @(posedge clk);
    chk({cdp[3], dcp[3]}, 2'b01);
    up <= 1'b1;
    for (int n = 0; n < 20 && vsw !== 4'h0; n++) @(posedge clk);
    chk(vsw, 4'h0);
    repeat (60) @(posedge clk);
  endtask

  task automatic t_button();
    apb(1'b1, A_DELAY, 32'h0000_0003);
    apb(1'b1, A_MODE0, 32'h0000_0000);
    repeat (2) begin
      btn <= 1'b1;
      repeat (4) @(posedge clk);
      btn <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    rd(A_DELAY);
    chk(rdv, 32'h0000_0000);
    rd(A_MODE0);
    chk(rdv, 32'h0000_0001);
    rd(A_LIMIT0 + 8'h04);
    chk(rdv, LIMIT_DEF_UA);
    chk({vsw, dsw}, 8'hFF);
  endtask

  task automatic t_boost();
    apb(1'b1, A_SYSCFG, 32'hD000_0000);
    cmd(OP_SAVE, 4'h0);
    chk({upb, dnb}, 4'h0);
    do_reset();
    repeat (2) @(posedge clk);
    chk({upb, dnb}, 4'hD);
    rd(A_SYSCFG);
    chk(rdv[31:28], 4'hD);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    do_reset();
    t_stagger();
    t_limit();
    t_switch();
    t_fault();
    t_mode();
    t_button();
    t_boost();
    print_verdict();
  end
endmodule
